/* File: rtl/sucfg_defines.vh */
// constants for the serial unit clock and mode configuration block
// Functional notes
// - Clock gate bit 2 of peripheral enable stops unit clock at 0, supplies at 1.
// - Each 4-bit prescaler field divides system clock by two to the field value.
// - Mode bit 15 picks prescaled clock a at 0, clock b at 1.
// - Mode bit 14 picks divided operation clock at 0, external serial clock at 1.
// - Mode bits 2:1 select clocked serial, asynchronous, two-wire; 11 is prohibited.
// - Mode bit 0 fires interrupt on transfer end at 0, buffer empty at 1.
// - Mode bit 8 allows software start only at 0, also receive pin edge in asynchronous mode at 1.
// - Mode bit 6 detects falling start edge at 0, rising at 1, inverting data.
`ifndef SUCFG_DEFINES_VH
`define SUCFG_DEFINES_VH
// register byte offsets on the bus
`define SUCFG_OFS_PCE        4'h0
`define SUCFG_OFS_SPS        4'h4
`define SUCFG_OFS_MODE       4'h8
`define SUCFG_OFS_STAT       4'hc
// register reset values
`define SUCFG_PCE_RST        8'h00
`define SUCFG_SPS_RST        16'h0000
`define SUCFG_MODE_RST       16'h0020
// field positions
`define SUCFG_PCE_GATE       2
`define SUCFG_MODE_CKS       15
`define SUCFG_MODE_CCS       14
`define SUCFG_MODE_STS       8
`define SUCFG_MODE_SIS       6
`define SUCFG_MODE_FHI       2
`define SUCFG_MODE_FLO       1
`define SUCFG_MODE_ISRC      0
// writable bit masks, other bits read as fixed
`define SUCFG_MODE_WMASK     16'hc147
`define SUCFG_MODE_FIXED     16'h0020
`define SUCFG_SPS_WMASK      16'h00ff
// function select encodings
`define SUCFG_FN_CSI         2'h0
`define SUCFG_FN_ASYNC       2'h1
`define SUCFG_FN_TWOWIRE     2'h2
`define SUCFG_FN_BAD         2'h3
// divider width for up to two to the fifteenth
`define SUCFG_DIV_W          15
`endif

/* File: rtl/sucfg_top.v */
// serial unit clock gate, prescaler and channel 0 mode configuration
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "sucfg_defines.vh"
module sucfg_top
(
   input  wire        clk_i,
   input  wire        rst_i,
   // classic wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire        wb_ack_o,
   // channel pins and events
   input  wire        serial_clk_pin_i,
   input  wire        rx_data_pin_i,
   input  wire        sw_start_i,
   input  wire        transfer_end_i,
   input  wire        buffer_empty_i,
   // derived clocks and controls to the channel
   output wire        unit_clk_en_o,
   output wire        prescaled_clock_a_o,
   output wire        prescaled_clock_b_o,
   output wire        operation_clk_en_o,
   output wire        transfer_clock_o,
   output wire [1:0]  function_mode_o,
   output wire        rx_data_o,
   output wire        channel_start_o,
   output wire        channel_irq_o
);

   reg  [7:0]                 pce_r;
   reg  [15:0]                sps_r;
   reg  [15:0]                mode_r;
   reg  [`SUCFG_DIV_W-1:0]    div_r;
   reg  [`SUCFG_DIV_W-1:0]    div_nxt;
   reg                        ack_r;
   reg  [31:0]                dat_r;
   reg                        bad_fn_r;
   reg  [1:0]                 sck_sync_r;
   reg  [1:0]                 rxd_sync_r;
   reg                        rxd_prev_r;
   reg                        tick_a_r;
   reg                        tick_b_r;
   reg                        transfer_clock_r;
   reg                        start_r;
   reg                        irq_r;
   reg                        rx_r;
   wire                       gate;
   wire                       bus_req;
   wire                       wr;
   wire                       tick_a;
   wire                       tick_b;
   wire                       op_tick;
   wire                       rxd;
   wire                       edge_seen;

   // strobe for the field value: true once every two to the n system clocks
   function tick_of;
      input [3:0]               n;
      input [`SUCFG_DIV_W-1:0]  cnt;
      reg   [`SUCFG_DIV_W-1:0]  mask;
      begin
         mask    = ~({`SUCFG_DIV_W{1'b1}} << n);
         tick_of = ((cnt & mask) == mask);
      end
   endfunction

   assign gate    = pce_r[`SUCFG_PCE_GATE];
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr      = bus_req & wb_we_i & wb_sel_i[0];

   // register writes; gated registers only load while the unit clock runs
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pce_r  <= `SUCFG_PCE_RST;
         sps_r  <= `SUCFG_SPS_RST;
         mode_r <= `SUCFG_MODE_RST;
      end
      else if (wr)
      begin
         case (wb_adr_i)
            `SUCFG_OFS_PCE:
               pce_r <= wb_dat_i[7:0];
            `SUCFG_OFS_SPS:
               if (gate)
                  sps_r <= wb_dat_i[15:0] & `SUCFG_SPS_WMASK;
            `SUCFG_OFS_MODE:
               if (gate && wb_sel_i[1])
                  mode_r <= (wb_dat_i[15:0] & `SUCFG_MODE_WMASK) | `SUCFG_MODE_FIXED;
            default:
               pce_r <= pce_r;
         endcase
      end
   end

   // bus answer: one cycle after the request, unmapped reads zero
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end
      else
      begin
         ack_r <= bus_req;
         case (wb_adr_i)
            `SUCFG_OFS_PCE:  dat_r <= {24'h000000, pce_r};
            `SUCFG_OFS_SPS:  dat_r <= {16'h0000, sps_r};
            `SUCFG_OFS_MODE: dat_r <= {16'h0000, mode_r};
            `SUCFG_OFS_STAT: dat_r <= {28'h0000000, rx_r, transfer_clock_r, bad_fn_r, gate};
            default:         dat_r <= 32'h00000000;
         endcase
      end
   end
   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;

   // free running prescaler counter, held while the gate is off
   always @*
   begin
      div_nxt = div_r;
      if (gate)
         div_nxt = div_r + {{(`SUCFG_DIV_W-1){1'b0}}, 1'b1};
   end

   assign tick_a = gate & tick_of(sps_r[3:0], div_r);
   assign tick_b = gate & tick_of(sps_r[7:4], div_r);
   // operation clock chooses between the two prescaled clocks; gate kills a stale pulse
   assign op_tick = gate & (mode_r[`SUCFG_MODE_CKS] ? tick_b_r : tick_a_r);

   // input synchronisers for external pins
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sck_sync_r <= 2'b00;
         rxd_sync_r <= 2'b11;
         rxd_prev_r <= 1'b1;
      end
      else
      begin
         sck_sync_r <= {sck_sync_r[0], serial_clk_pin_i};
         rxd_sync_r <= {rxd_sync_r[0], rx_data_pin_i};
         rxd_prev_r <= rxd_sync_r[1];
      end
   end
   assign rxd = rxd_sync_r[1];
   // start edge by polarity: falling at 0, rising at 1
   assign edge_seen = mode_r[`SUCFG_MODE_SIS] ? (~rxd_prev_r & rxd)
                                              : (rxd_prev_r & ~rxd);

   // clocked outputs to the channel
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_r    <= {`SUCFG_DIV_W{1'b0}};
         tick_a_r <= 1'b0;
         tick_b_r <= 1'b0;
         transfer_clock_r   <= 1'b0;
         start_r  <= 1'b0;
         irq_r    <= 1'b0;
         rx_r     <= 1'b0;
         bad_fn_r <= 1'b0;
      end
      else
      begin
         div_r    <= div_nxt;
         tick_a_r <= tick_a;
         tick_b_r <= tick_b;
         // transfer clock: divided operation clock or external pin
         if (!gate)
            transfer_clock_r <= 1'b0;
         else if (mode_r[`SUCFG_MODE_CCS])
            transfer_clock_r <= sck_sync_r[1];
         else if (op_tick)
            transfer_clock_r <= ~transfer_clock_r;
         // start: software always, pin edge only when selected in async mode
         start_r  <= gate & (sw_start_i |
                     (mode_r[`SUCFG_MODE_STS] & edge_seen &
                      (mode_r[2:1] == `SUCFG_FN_ASYNC)));
         // interrupt source by mode bit 0
         irq_r    <= gate & (mode_r[`SUCFG_MODE_ISRC] ? buffer_empty_i
                                                      : transfer_end_i);
         // received data inverted for rising start edge
         rx_r     <= rxd ^ mode_r[`SUCFG_MODE_SIS];
         // prohibited function code is flagged in status
         bad_fn_r <= (mode_r[2:1] == `SUCFG_FN_BAD);
      end
   end

   assign unit_clk_en_o       = gate;
   assign prescaled_clock_a_o = tick_a_r & gate;
   assign prescaled_clock_b_o = tick_b_r & gate;
   assign operation_clk_en_o  = op_tick;
   assign transfer_clock_o    = transfer_clock_r;
   // prohibited code falls back to clocked serial mode with no one-cycle leak
   assign function_mode_o     = (mode_r[`SUCFG_MODE_FHI:`SUCFG_MODE_FLO] == `SUCFG_FN_BAD)
                                ? `SUCFG_FN_CSI
                                : mode_r[`SUCFG_MODE_FHI:`SUCFG_MODE_FLO];
   assign rx_data_o           = rx_r;
   assign channel_start_o     = start_r;
   assign channel_irq_o       = irq_r;

endmodule
`default_nettype wire

/* File: tb/sucfg_sva.sv */
// assertion checker for the serial unit configuration block
`timescale 1ns/100ps
`default_nettype none
module sucfg_sva
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       unit_clk_en_o,
   input wire logic       prescaled_clock_a_o,
   input wire logic       prescaled_clock_b_o,
   input wire logic       operation_clk_en_o,
   input wire logic       transfer_clock_o,
   input wire logic [1:0] function_mode_o,
   input wire logic       channel_start_o,
   input wire logic       channel_irq_o,
   input wire logic       transfer_end_i,
   input wire logic       buffer_empty_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // bus answers next cycle, for one cycle
   ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("missing ack");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   // clock and channel outputs
   gate_off_a: assert property (
      !unit_clk_en_o |-> !prescaled_clock_a_o && !prescaled_clock_b_o) else $error("gated");
   op_sel_a: assert property (
      operation_clk_en_o |-> prescaled_clock_a_o || prescaled_clock_b_o) else $error("op");
   transfer_clock_off_a: assert property (
      !unit_clk_en_o && !$past(unit_clk_en_o) |-> !transfer_clock_o) else $error("transfer_clock");
   fn_legal_a: assert property (function_mode_o != 2'h3) else $error("fn");
   irq_src_a: assert property (
      channel_irq_o |-> $past(transfer_end_i) || $past(buffer_empty_i)) else $error("irq");
   start_gate_a: assert property (
      channel_start_o |-> $past(unit_clk_en_o)) else $error("start");
   cover property (prescaled_clock_b_o && operation_clk_en_o);
   cover property (channel_start_o);
   cover property (channel_irq_o);
endmodule
`default_nettype wire

/* File: tb/tb_sucfg_top.sv */
// self-checking bench for the serial unit configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_sucfg_top;
   logic        clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic        serial_clk_pin_i = 1'h0, rx_data_pin_i = 1'h1, sw_start_i = 1'h0, p;
   logic        transfer_end_i = 1'h0, buffer_empty_i = 1'h0, wb_ack_o, unit_clk_en_o;
   logic        prescaled_clock_a_o, prescaled_clock_b_o, operation_clk_en_o;
   logic        transfer_clock_o, rx_data_o, channel_start_o, channel_irq_o;
   logic [1:0]  function_mode_o;
   integer      miscompares = 0, comparisons = 0, i, k, na, nb, no, nt;
   sucfg_top sucfg_top_inst (.*);
   always #2.5 clk_i = ~clk_i;
   // compare and count
   task chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e)
      begin
         miscompares++;
         $display("[ERR] %0t got %h want %h", $time, s, e);
      end
   endtask
   task end_sim;
      $display("compares %0d mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one classic cycle, read data left in q
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (wb_ack_o !== 1'h1 && k < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      if (wb_ack_o !== 1'h1)
      begin
         miscompares++;
         end_sim;
      end
   endtask
   // count outputs over 64 settled cycles
   task meas;
      na = 0; nb = 0; no = 0; nt = 0;
      repeat (4) @(negedge clk_i);
      p = transfer_clock_o;
      repeat (64)
      begin
         @(negedge clk_i);
         na += prescaled_clock_a_o;
         nb += prescaled_clock_b_o;
         no += operation_clk_en_o;
         nt += (transfer_clock_o != p);
         p = transfer_clock_o;
      end
   endtask
   task t_regs;
      bus(1'h0, 4'h0, 32'h0);
      chk(q, 32'h0);
      bus(1'h1, 4'h8, 32'hffff);
      bus(1'h0, 4'h8, 32'h0);
      chk(q, 32'h20);
      bus(1'h1, 4'h0, 32'h4);
      chk(unit_clk_en_o, 1'h1);
      bus(1'h1, 4'h8, 32'hffff);
      bus(1'h0, 4'h8, 32'h0);
      chk(q, 32'hc167);
      $display("regs done");
   endtask
   task t_div;
      for (i = 0; i < 4; i++)
      begin
         bus(1'h1, 4'h4, 32'(((i + 1) << 4) | i));
         bus(1'h1, 4'h8, {16'h0, i[0], 15'h0});
         meas;
         chk(na, 64 >> i);
         chk(nb, 64 >> (i + 1));
         chk(no, 64 >> (i + i[0]));
         chk(nt, 64 >> (i + i[0]));
      end
      bus(1'h1, 4'h0, 32'h0);
      meas;
      chk(na + nb, 0);
      bus(1'h1, 4'h0, 32'h4);
      $display("div done");
   endtask
   task t_pin;
      bus(1'h1, 4'h8, 32'h4040);
      for (i = 0; i < 2; i++)
      begin
         serial_clk_pin_i <= i[0];
         rx_data_pin_i <= i[0];
         repeat (6) @(posedge clk_i);
         #1 chk(transfer_clock_o, i[0]);
         chk(rx_data_o, !i[0]);
      end
      for (i = 0; i < 4; i++)
      begin
         bus(1'h1, 4'h8, 32'(i * 2));
         repeat (2) @(posedge clk_i);
         #1 chk(function_mode_o, (i == 3) ? 0 : i);
         bus(1'h0, 4'hc, 32'h0);
         chk(q[1:0], (i == 3) ? 2'h3 : 2'h1);
      end
      $display("pin and mode done");
   endtask
   task t_evt;
      for (i = 0; i < 2; i++)
      begin
         bus(1'h1, 4'h8, 32'(i));
         transfer_end_i <= 1'h1;
         @(posedge clk_i);
         transfer_end_i <= 1'h0;
         buffer_empty_i <= 1'h1;
         #1 chk(channel_irq_o, !i[0]);
         @(posedge clk_i);
         buffer_empty_i <= 1'h0;
         #1 chk(channel_irq_o, i[0]);
         sw_start_i <= i[0];
         @(posedge clk_i);
         sw_start_i <= 1'h0;
         #1 chk(channel_start_o, i[0]);
         bus(1'h1, 4'h8, 32'h0102 | (i << 6));
         rx_data_pin_i <= !i[0];
         repeat (6) @(posedge clk_i);
         rx_data_pin_i <= i[0];
         for (k = 0; k < 8 && channel_start_o !== 1'h1; k++)
            @(posedge clk_i) #1;
         chk(channel_start_o, 1'h1);
      end
      $display("events done");
   endtask
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      t_regs;
      t_div;
      t_pin;
      t_evt;
      end_sim;
   end
endmodule
bind sucfg_top sucfg_sva sucfg_sva_inst (.*);
`default_nettype wire
